// >>> verilog/fcs_regs.vh
// Command codes, status field positions, reset values and timing counts
`ifndef FCS_REGS_VH
`define FCS_REGS_VH

`define FCS_CMD_CFG_SETUP   16'h0060
`define FCS_CMD_RSW_CONFIRM 16'h0003
`define FCS_CMD_DCW_CONFIRM 16'h0004
`define FCS_CMD_LOCK        16'h0001
`define FCS_CMD_LOCKDOWN    16'h002f
`define FCS_CMD_OTP         16'h00c0
`define FCS_CMD_CLR_STATUS  16'h0050
`define FCS_CMD_RD_ARRAY    16'h00ff
`define FCS_CMD_RD_STATUS   16'h0070
`define FCS_CMD_RD_IDENT    16'h0090
`define FCS_CMD_RD_QUERY    16'h0098
`define FCS_CMD_WORD_PGM    16'h0041
`define FCS_CMD_BUF_PGM     16'h00e9
`define FCS_CMD_FAST_PGM    16'h0080
`define FCS_CMD_ERASE       16'h0020
`define FCS_CMD_CONFIRM     16'h00d0
`define FCS_CMD_SUSPEND     16'h00b0
`define FCS_CMD_BLANK       16'h00bc

// Read modes per partition
`define FCS_MODE_ARRAY      2'h0
`define FCS_MODE_STATUS     2'h1
`define FCS_MODE_IDENT      2'h2
`define FCS_MODE_QUERY      2'h3

// Identifier-space offset of the read setup word
`define FCS_RSW_OFFSET      16'h0005

// Status word fields
`define FCS_SR_REGION_HI    9
`define FCS_SR_REGION_LO    8
`define FCS_SR_READY        7
`define FCS_SR_ERS_SUSP     6
`define FCS_SR_ERR_HI       5
`define FCS_SR_ERR_LO       4
`define FCS_SR_VPP_ERR      3
`define FCS_SR_PGM_SUSP     2
`define FCS_SR_LOCK_ERR     1
`define FCS_SR_PART         0

// Reset values
`define FCS_SR_RESET        16'h0080
`define FCS_RSW_RESET       16'h8000
`define FCS_DCW_RESET       16'h0004

// Array operation time in ns and derived cycles at 100 MHz
`define FCS_CLK_NS          10
`define FCS_OP_NS           640
`define FCS_OP_CYCLES       (`FCS_OP_NS / `FCS_CLK_NS)

`endif

// >>> verilog/fcs_command_unit.v
// Command interpreter and status word for a partitioned flash
`timescale 1ns/1ps
`include "fcs_regs.vh"

module fcs_command_unit #(
    parameter OP_CYCLES = `FCS_OP_CYCLES
) (
    // Clock and reset
    input  wire        core_clk,
    input  wire        arst_n,
    // Host bus, one cycle per completed write or read
    input  wire        busWrite,
    input  wire        busRead,
    input  wire [25:0] busAddr,
    input  wire [15:0] busData,
    // Array side status
    input  wire        programVoltageLow,
    input  wire        blockLocked,
    input  wire        arrayFail,
    input  wire [1:0]  regionError,
    // Read path
    output reg  [15:0] readData,
    output reg  [1:0]  readMode,
    // Configuration words
    output reg  [15:0] readSetupWord,
    output reg  [15:0] driverConfigurationWord,
    // Array commands as one-cycle pulses, then operation address, data and status word
    output reg         pgmStart,
    output reg         otpStart,
    output reg         bufPgmStart,
    output reg         fastPgmStart,
    output reg         eraseStart,
    output reg         blankStart,
    output reg         lockSet,
    output reg         lockClear,
    output reg         lockDownSet,
    output reg  [25:0] opAddr,
    output reg  [15:0] opData,
    output reg  [15:0] deviceStateWord
);

    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_CFG   = 3'h1;
    localparam [2:0] ST_ERASE = 3'h2;
    localparam [2:0] ST_BUF   = 3'h3;
    localparam [2:0] ST_FAST  = 3'h4;
    localparam [2:0] ST_BLANK = 3'h5;
    localparam [2:0] ST_PGM   = 3'h6;
    localparam [2:0] ST_OTP   = 3'h7;

    localparam [1:0] OP_NONE  = 2'h0;
    localparam [1:0] OP_PGM   = 2'h1;
    localparam [1:0] OP_ERASE = 2'h2;
    localparam [1:0] OP_BLANK = 2'h3;

    reg [2:0]  seq_q;
    reg [15:0] modes_q;
    reg [1:0]  op_q;
    reg [2:0]  opPart_q;
    reg [15:0] opCnt_q;
    reg        ersSusp_q;
    reg        pgmSusp_q;
    reg [15:0] savedCnt_q;
    reg [1:0]  errCode_q;
    reg [1:0]  region_q;
    reg        vppErr_q;
    reg        lockErr_q;

    // Partition index is the top three address bits
    wire [2:0] part    = busAddr[25:23];
    wire       busy    = (op_q != OP_NONE);

    function [1:0] mode_of;
        input [15:0] modes;
        input [2:0]  idx;
        begin
            mode_of = modes[idx*2 +: 2];
        end
    endfunction

    function [15:0] set_mode;
        input [15:0] modes;
        input [2:0]  idx;
        input [1:0]  m;
        reg   [15:0] t;
        begin
            t = modes;
            t[idx*2 +: 2] = m;
            set_mode = t;
        end
    endfunction

    // Code left in bits 5:4 by an operation that completes
    function [1:0] end_code;
        input [1:0] op;
        input       fail;
        input       rgnErr;
        begin
            end_code = 2'h0;
            if (fail)
                end_code = (op == OP_PGM) ? 2'h1 : 2'h2;
            if (rgnErr)
                end_code = end_code | 2'h1;
        end
    endfunction

    // Outcome of an operation ending this cycle; a clear in the same cycle must not hide it
    wire       opEnds    = busy && (programVoltageLow || opCnt_q == 16'h0000);
    wire       endVpp    = busy && programVoltageLow;
    wire       endOk     = opEnds && !endVpp;
    wire       endLock   = endOk && blockLocked && (op_q != OP_BLANK);
    wire       endRgn    = endOk && (op_q == OP_PGM) && (regionError != 2'h0);
    wire       endFail   = endOk && !endLock && arrayFail;
    wire [1:0] endErr    = end_code(op_q, endFail, endRgn);
    wire [1:0] endRegion = endRgn ? regionError : 2'h0;

    // Status word assembly; upper bits hard zero
    wire [15:0] statusNow = {6'h00, region_q, ~busy, ersSusp_q, errCode_q,
                             vppErr_q, pgmSusp_q, lockErr_q,
                             busy ? (opPart_q != part) : 1'b0};

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            seq_q                   <= ST_IDLE;
            modes_q                 <= 16'h0000;
            op_q                    <= OP_NONE;
            opPart_q                <= 3'h0;
            opCnt_q                 <= 16'h0000;
            ersSusp_q               <= 1'b0;
            pgmSusp_q               <= 1'b0;
            savedCnt_q              <= 16'h0000;
            errCode_q               <= 2'h0;
            region_q                <= 2'h0;
            vppErr_q                <= 1'b0;
            lockErr_q               <= 1'b0;
            readSetupWord           <= `FCS_RSW_RESET;
            driverConfigurationWord <= `FCS_DCW_RESET;
            readData                <= 16'h0000;
            readMode                <= `FCS_MODE_ARRAY;
            pgmStart                <= 1'b0;
            otpStart                <= 1'b0;
            bufPgmStart             <= 1'b0;
            fastPgmStart            <= 1'b0;
            eraseStart              <= 1'b0;
            blankStart              <= 1'b0;
            lockSet                 <= 1'b0;
            lockClear               <= 1'b0;
            lockDownSet             <= 1'b0;
            opAddr                  <= 26'h0000000;
            opData                  <= 16'h0000;
            deviceStateWord         <= `FCS_SR_RESET;
        end else begin
            pgmStart     <= 1'b0;
            otpStart     <= 1'b0;
            bufPgmStart  <= 1'b0;
            fastPgmStart <= 1'b0;
            eraseStart   <= 1'b0;
            blankStart   <= 1'b0;
            lockSet      <= 1'b0;
            lockClear    <= 1'b0;
            lockDownSet  <= 1'b0;
            deviceStateWord <= statusNow;

            // Running operation: count down, then record outcome
            if (busy) begin
                if (endVpp) begin
                    vppErr_q <= 1'b1;
                    op_q     <= OP_NONE;
                end else if (opEnds) begin
                    op_q      <= OP_NONE;
                    lockErr_q <= lockErr_q | endLock;
                    errCode_q <= errCode_q | endErr;
                    region_q  <= region_q | endRegion;
                end else begin
                    opCnt_q <= opCnt_q - 16'h0001;
                end
            end

            // Reads never disturb a pending sequence
            if (busRead) begin
                readMode <= mode_of(modes_q, part);
                if (mode_of(modes_q, part) == `FCS_MODE_STATUS)
                    readData <= statusNow;
                else if (mode_of(modes_q, part) == `FCS_MODE_IDENT &&
                         busAddr[15:0] == `FCS_RSW_OFFSET)
                    readData <= readSetupWord;
                else
                    readData <= 16'h0000;
            end

            if (busWrite) begin
                case (seq_q)
                ST_IDLE: begin
                    opAddr <= busAddr;
                    case (busData)
                    `FCS_CMD_RD_ARRAY:
                        modes_q <= set_mode(modes_q, part, `FCS_MODE_ARRAY);
                    `FCS_CMD_RD_STATUS:
                        modes_q <= set_mode(modes_q, part, `FCS_MODE_STATUS);
                    `FCS_CMD_RD_IDENT:
                        modes_q <= set_mode(modes_q, part, `FCS_MODE_IDENT);
                    `FCS_CMD_RD_QUERY:
                        modes_q <= set_mode(modes_q, part, `FCS_MODE_QUERY);
                    `FCS_CMD_CLR_STATUS: begin
                        // An outcome landing in this same cycle survives the clear
                        errCode_q <= endErr;
                        region_q  <= endRegion;
                        vppErr_q  <= endVpp;
                        lockErr_q <= endLock;
                        modes_q   <= set_mode(modes_q, part, `FCS_MODE_STATUS);
                    end
                    `FCS_CMD_CFG_SETUP: begin
                        seq_q   <= ST_CFG;
                        modes_q <= set_mode(modes_q, part, `FCS_MODE_STATUS);
                    end
                    `FCS_CMD_ERASE:     seq_q <= ST_ERASE;
                    `FCS_CMD_BUF_PGM:   seq_q <= ST_BUF;
                    `FCS_CMD_FAST_PGM:  seq_q <= ST_FAST;
                    `FCS_CMD_BLANK:     seq_q <= ST_BLANK;
                    `FCS_CMD_WORD_PGM: begin
                        seq_q   <= ST_PGM;
                        modes_q <= set_mode(modes_q, part, `FCS_MODE_STATUS);
                    end
                    `FCS_CMD_OTP:       seq_q <= ST_OTP;
                    `FCS_CMD_SUSPEND: begin
                        if (op_q == OP_PGM) begin
                            pgmSusp_q  <= 1'b1;
                            savedCnt_q <= opCnt_q;
                            op_q       <= OP_NONE;
                        end else if (op_q == OP_ERASE) begin
                            ersSusp_q  <= 1'b1;
                            savedCnt_q <= opCnt_q;
                            op_q       <= OP_NONE;
                        end
                    end
                    `FCS_CMD_CONFIRM: begin
                        // Only one saved context: a nested program resumes first
                        if (pgmSusp_q && !busy) begin
                            pgmSusp_q <= 1'b0;
                            op_q      <= OP_PGM;
                            opCnt_q   <= savedCnt_q;
                            modes_q   <= set_mode(modes_q, opPart_q, `FCS_MODE_STATUS);
                        end else if (ersSusp_q && !busy) begin
                            ersSusp_q <= 1'b0;
                            op_q      <= OP_ERASE;
                            opCnt_q   <= savedCnt_q;
                            modes_q   <= set_mode(modes_q, opPart_q, `FCS_MODE_STATUS);
                        end
                    end
                    default: begin
                        errCode_q <= 2'h3;
                        region_q  <= 2'h3;
                    end
                    endcase
                end
                // Data write that follows a one-cycle program setup
                ST_PGM, ST_OTP: begin
                    seq_q    <= ST_IDLE;
                    opAddr   <= busAddr;
                    opData   <= busData;
                    pgmStart <= (seq_q == ST_PGM);
                    otpStart <= (seq_q == ST_OTP);
                    if (!busy) begin
                        op_q     <= OP_PGM;
                        opPart_q <= part;
                        opCnt_q  <= OP_CYCLES[15:0];
                    end
                end
                default: begin
                    // Second write of a two-cycle command
                    seq_q  <= ST_IDLE;
                    opAddr <= busAddr;
                    if (seq_q == ST_CFG && busData == `FCS_CMD_RSW_CONFIRM) begin
                        readSetupWord <= busAddr[15:0];
                        modes_q <= set_mode(modes_q, part, `FCS_MODE_ARRAY);
                    end else if (seq_q == ST_CFG && busData == `FCS_CMD_DCW_CONFIRM) begin
                        driverConfigurationWord <= busAddr[15:0];
                        modes_q <= set_mode(modes_q, part, `FCS_MODE_ARRAY);
                    end else if (seq_q == ST_CFG && busData == `FCS_CMD_LOCK) begin
                        lockSet <= 1'b1;
                    end else if (seq_q == ST_CFG && busData == `FCS_CMD_CONFIRM) begin
                        lockClear <= 1'b1;
                    end else if (seq_q == ST_CFG && busData == `FCS_CMD_LOCKDOWN) begin
                        lockDownSet <= 1'b1;
                    end else if (busData == `FCS_CMD_CONFIRM && seq_q != ST_CFG && !busy) begin
                        modes_q  <= set_mode(modes_q, part, `FCS_MODE_STATUS);
                        opPart_q <= part;
                        opCnt_q  <= OP_CYCLES[15:0];
                        case (seq_q)
                        ST_ERASE: begin
                            eraseStart <= 1'b1;
                            op_q       <= OP_ERASE;
                        end
                        ST_BLANK: begin
                            blankStart <= 1'b1;
                            op_q       <= OP_BLANK;
                        end
                        ST_BUF: begin
                            bufPgmStart <= 1'b1;
                            op_q        <= OP_PGM;
                        end
                        default: begin
                            fastPgmStart <= 1'b1;
                            op_q         <= OP_PGM;
                        end
                        endcase
                    end else begin
                        // Any other write aborts; status shows sequence error
                        errCode_q <= 2'h3;
                    end
                end
                endcase
            end
        end
    end

endmodule // fcs_command_unit

// >>> sim/fcs_host_model.sv
// Host bus model issuing one-cycle write and read strobes
`timescale 1ns/1ps
module fcs_host_model (
    // Clock
    input  wire        core_clk,
    // Bus strobes
    output reg         busWrite,
    output reg         busRead,
    output reg  [25:0] busAddr,
    output reg  [15:0] busData,
    // Read return
    input  wire [15:0] readData,
    input  wire [1:0]  readMode
);
    initial begin
        busWrite = 1'b0;
        busRead  = 1'b0;
        busAddr  = 26'h0;
        busData  = 16'h0;
    end
    // Setup, confirm and data words each go out whole
    task wr(input [25:0] a, input [15:0] d);
        @(posedge core_clk);
        busWrite <= 1'b1;
        busAddr  <= a;
        busData  <= d;
        @(posedge core_clk);
        busWrite <= 1'b0;
        busAddr  <= ~a;  // Released lines must not keep the last value
        busData  <= ~d;
        @(negedge core_clk);
    endtask
    // Reads may sit between setup and confirm
    task rd(input [25:0] a, output [15:0] d, output [1:0] m);
        @(posedge core_clk);
        busRead <= 1'b1;
        busAddr <= a;
        @(posedge core_clk);
        busRead <= 1'b0;
        busAddr <= ~a;
        @(negedge core_clk);
        d = readData;
        m = readMode;
    endtask
endmodule // fcs_host_model

// >>> sim/fcs_command_unit_sva.sv
// Concurrent checks on status word, start pulses and read setup word
`timescale 1ns/1ps
module fcs_command_unit_sva #(
    parameter OP_CYCLES = 64
) (
    input wire        core_clk,
    input wire        arst_n,
    input wire        busWrite,
    input wire [25:0] busAddr,
    input wire [15:0] busData,
    input wire        programVoltageLow,
    input wire [15:0] readSetupWord,
    input wire [15:0] opData,
    input wire        pgmStart,
    input wire        eraseStart,
    input wire        lockSet,
    input wire [15:0] deviceStateWord
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    int busyCnt;
    // A hung operation would otherwise just look like a slow one
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) busyCnt <= 0;
        else if (deviceStateWord[7]) busyCnt <= 0;
        else busyCnt <= busyCnt + 1;
    end
    sequence sw(logic [15:0] c);
        busWrite && busData == c;
    endsequence
    AST_RSV_ZERO: assert property (deviceStateWord[15:10] == 6'h00)
        else $error("reserved status bits not zero");
    AST_SEQ_ERR: assert property (sw(16'h0020) ##2 sw(16'h00ff)
        |-> ##2 deviceStateWord[7] && deviceStateWord[5:4] == 2'h3)
        else $error("no sequence error after broken pair");
    AST_CLR: assert property (sw(16'h0050) |-> ##2 (deviceStateWord & 16'h033a) == 16'h0)
        else $error("error bits survive clear");
    AST_ERASE_GO: assert property ((busWrite && busData == 16'h0020 && deviceStateWord[7])
        ##2 sw(16'h00d0) |=> eraseStart)
        else $error("erase not started on confirm");
    AST_PGM_DATA: assert property ((busWrite && busData == 16'h0041 && deviceStateWord[7]
        && !programVoltageLow) ##2 busWrite |=> pgmStart && opData == $past(busData))
        else $error("program data not issued");
    AST_BUSY_GO: assert property (eraseStart |=> !deviceStateWord[7])
        else $error("busy not shown after start");
    AST_BUSY_MAX: assert property (busyCnt <= OP_CYCLES + 3)
        else $error("busy too long");
    AST_LOCK: assert property (sw(16'h0060) ##2 sw(16'h0001) |=> lockSet)
        else $error("lock not set");
    AST_RSW: assert property (sw(16'h0060) ##2 sw(16'h0003)
        |=> readSetupWord == $past(busAddr[15:0]))
        else $error("read setup word not loaded");
    cover property (eraseStart);
    cover property (deviceStateWord[6]);
    cover property (deviceStateWord[5:4] == 2'h3);
endmodule // fcs_command_unit_sva
bind fcs_command_unit fcs_command_unit_sva #(.OP_CYCLES(OP_CYCLES)) u_fcs_command_unit_sva (
    .core_clk(core_clk), .arst_n(arst_n), .busWrite(busWrite), .busAddr(busAddr),
    .busData(busData), .programVoltageLow(programVoltageLow), .readSetupWord(readSetupWord),
    .opData(opData), .pgmStart(pgmStart), .eraseStart(eraseStart), .lockSet(lockSet),
    .deviceStateWord(deviceStateWord));

// >>> sim/test_flash_command_status_unit.sv
// Self-checking bench for the flash command and status unit
`timescale 1ns/1ps
module test_flash_command_status_unit;
    localparam [25:0] P1 = 26'h0800000, P2 = 26'h1000000, P3 = 26'h1800000;
    logic        core_clk = 1'b0, arst_n = 1'b0, busWrite, busRead;
    logic        programVoltageLow = 1'b0, blockLocked = 1'b0, arrayFail = 1'b0;
    logic [1:0]  regionError = 2'h0, readMode, rm;
    logic [15:0] readData, readSetupWord, driverConfigurationWord, opData, deviceStateWord, rv;
    logic [25:0] busAddr, opAddr;
    logic [15:0] busData;
    logic [8:0]  pulses;
    int          bad_count = 0, num_checks = 0, cycles = 0, snap, pulseCnt[9] = '{default: 0};
    logic [15:0] c1[9] = '{16'h0041, 16'h0041, 16'h0020, 16'h0041, 16'h0041, 16'h00bc,
                           16'h00c0, 16'h00e9, 16'h0080};
    logic [15:0] c2[9] = '{16'h1234, 16'h1234, 16'h00d0, 16'h5678, 16'h5678, 16'h00d0,
                           16'habcd, 16'h00d0, 16'h00d0};
    logic [4:0]  opIn[9] = '{5'h10, 5'h08, 5'h04, 5'h04, 5'h02, 5'h04, 5'h00, 5'h00, 5'h00};
    logic [15:0] opM[9] = '{16'h0088, 16'h0082, 16'h00b0, 16'h00b0, 16'h03b0, 16'h00b0,
                            16'h00b0, 16'h00b0, 16'h00b0};
    logic [15:0] opE[9] = '{16'h0088, 16'h0082, 16'h00a0, 16'h0090, 16'h0290, 16'h00a0,
                            16'h0080, 16'h0080, 16'h0080};
    int          opP[9] = '{0, 0, 4, 0, 0, 5, 1, 2, 3};
    always #5 core_clk = ~core_clk;
    fcs_host_model u_host (.core_clk(core_clk), .busWrite(busWrite), .busRead(busRead),
        .busAddr(busAddr), .busData(busData), .readData(readData), .readMode(readMode));
    fcs_command_unit #(.OP_CYCLES(40)) u_fcs_command_unit (.core_clk(core_clk),
        .arst_n(arst_n), .busWrite(busWrite), .busRead(busRead), .busAddr(busAddr),
        .busData(busData), .programVoltageLow(programVoltageLow), .blockLocked(blockLocked),
        .arrayFail(arrayFail), .regionError(regionError), .readData(readData),
        .readMode(readMode), .readSetupWord(readSetupWord),
        .driverConfigurationWord(driverConfigurationWord), .pgmStart(pulses[0]),
        .otpStart(pulses[1]), .bufPgmStart(pulses[2]), .fastPgmStart(pulses[3]),
        .eraseStart(pulses[4]), .blankStart(pulses[5]), .lockSet(pulses[6]),
        .lockClear(pulses[7]), .lockDownSet(pulses[8]), .opAddr(opAddr), .opData(opData),
        .deviceStateWord(deviceStateWord));
    always @(posedge core_clk) begin
        for (int k = 0; k < 9; k++) pulseCnt[k] += pulses[k];
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            complete_run();
        end
    end
    task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task waitBit(input int b, input logic v, input int lim);
        for (int n = 0; n < lim && deviceStateWord[b] !== v; n++) @(negedge core_clk);
    endtask
    task waitReady();
        waitBit(7, 1'b0, 8);
        waitBit(7, 1'b1, 400);
        chk("ready", {15'h0, deviceStateWord[7]}, 16'h1);
    endtask
    task run(input [15:0] a, input [15:0] b);
        u_host.wr(P3, a);
        u_host.wr(P3, b);
        waitReady();
    endtask
    task complete_run();
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        @(negedge core_clk);
        chk("status", deviceStateWord, 16'h0080);
        chk("rsw", readSetupWord, 16'h8000);
        chk("dcw", driverConfigurationWord, 16'h0004);
        u_host.rd(P2, rv, rm);
        chk("mode", {14'h0, rm}, 16'h0);
        for (int i = 0; i < 4; i++) begin
            u_host.wr(P1, 16'h0070 + (i == 0 ? 16'h008f : 16'h0000) + (i > 1 ? 16'h0020 : 16'h0)
                + (i == 3 ? 16'h0008 : 16'h0));
            u_host.rd(P1 | 26'h5, rv, rm);
            chk("mode", {14'h0, rm}, 16'(i));
            chk("data", rv, i == 1 ? 16'h0080 : (i == 2 ? 16'h8000 : 16'h0));
        end
        u_host.rd(P2, rv, rm);
        chk("mode", {14'h0, rm}, 16'h0);
        u_host.wr(P2 | 26'h1234, 16'h0060);
        u_host.rd(P2, rv, rm);
        chk("mode", {14'h0, rm}, 16'h1);
        u_host.wr(P2 | 26'h1234, 16'h0003);
        chk("rsw", readSetupWord, 16'h1234);
        u_host.rd(P2, rv, rm);
        chk("mode", {14'h0, rm}, 16'h0);
        u_host.wr(26'h2, 16'h0060);
        u_host.wr(26'h2, 16'h0004);
        chk("dcw", driverConfigurationWord, 16'h0002);
        u_host.wr(P2 | 26'h8000, 16'h0060);
        u_host.wr(P2 | 26'h8000, 16'h0003);
        chk("rsw", readSetupWord, 16'h8000);
        chk("opaddr", opAddr[25:10], 16'h4020);
        for (int i = 0; i < 3; i++) begin
            u_host.wr(P3, i == 0 ? 16'h0020 : (i == 1 ? 16'h0060 : 16'h0077));
            if (i < 2) u_host.wr(P3, i == 0 ? 16'h00ff : 16'h00bc);
            @(negedge core_clk);
            chk("seqerr", deviceStateWord & 16'h03b0, i < 2 ? 16'h00b0 : 16'h03b0);
            u_host.wr(P1, 16'h0050);
            @(negedge core_clk);
            chk("clear", deviceStateWord, 16'h0080);
        end
        for (int i = 0; i < 9; i++) begin
            @(posedge core_clk);
            {programVoltageLow, blockLocked, arrayFail, regionError} <= opIn[i];
            snap = pulseCnt[opP[i]];
            run(c1[i], c2[i]);
            chk("status", deviceStateWord & opM[i], opE[i]);
            chk("pulse", 16'(pulseCnt[opP[i]] - snap), 16'h1);
            u_host.rd(P3, rv, rm);
            if (i != 6) chk("mode", {14'h0, rm}, 16'h1);
            u_host.wr(P3, 16'h0050);
        end
        @(posedge core_clk);
        arrayFail <= 1'b1;
        run(16'h0020, 16'h00d0);
        @(posedge core_clk);
        arrayFail <= 1'b0;
        run(16'h0020, 16'h00d0);
        chk("sticky", deviceStateWord & 16'h0030, 16'h0020);
        u_host.wr(P3, 16'h0050);
        for (int i = 0; i < 3; i++) begin
            snap = pulseCnt[6 + i];
            u_host.wr(P3, 16'h0060);
            u_host.wr(P3, i == 0 ? 16'h0001 : (i == 1 ? 16'h00d0 : 16'h002f));
            @(negedge core_clk);
            chk("lock", 16'(pulseCnt[6 + i] - snap), 16'h1);
        end
        for (int i = 0; i < 2; i++) begin
            u_host.wr(P3, i == 0 ? 16'h0020 : 16'h0041);
            u_host.wr(P3, i == 0 ? 16'h00d0 : 16'h1111);
            waitBit(7, 1'b0, 8);
            u_host.rd(P3, rv, rm);
            chk("part", rv & 16'h0081, 16'h0000);
            u_host.rd(P1, rv, rm);
            chk("part", rv & 16'h0081, 16'h0001);
            u_host.wr(P1, 16'h00b0);
            waitBit(i == 0 ? 6 : 2, 1'b1, 20);
            chk("suspend", deviceStateWord & 16'h0044, i == 0 ? 16'h0040 : 16'h0004);
            u_host.wr(P1, 16'h00d0);
            waitReady();
            chk("resume", deviceStateWord & 16'h0044, 16'h0000);
        end
        complete_run();
    end
endmodule // test_flash_command_status_unit
